// >>> core/uaf_dev.sv
// Serial port with timer baud generation and ninth-bit address filter
`timescale 1ns/1ps
module uaf_dev (
  // Clock, reset, clock enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // CPU register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Interrupt request
  output logic irq_o,
  // External timer clock pins
  input wire logic ext_osc_i,
  input wire logic timer1_external_input_i,
  // Serial line
  uaf_line_if.dev line
);
  typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_STOP} uaf_tx_e;
  typedef enum logic {RX_IDLE, RX_BITS} uaf_rx_e;
  logic frame_format_select_r; // 9-bit mode when set
  logic address_filter_enable_r; // Ninth or stop bit filter
  logic receive_enable_bit_r; // Receiver enabled
  logic tx_ninth_bit_r; // Ninth bit to send
  logic rx_ninth_bit_r; // Received ninth or stop bit
  logic tx_done_flag_r; // Transmit done
  logic rx_done_flag_r; // Receive done
  logic [7:0] baud_reload_value_r; // Timer reload
  logic [7:0] baud_timer_low_count_r; // Transmit timer
  logic [7:0] rx_tmr_r; // Hidden receive timer copy
  logic tmr_run_r; // Timer enable
  logic [2:0] clk_sel_r; // Timer clock source
  logic [7:0] rx_buf_r; // Buffered received byte
  logic [7:0] tx_hold_r; // Transmit register
  logic tx_pend_r; // Write waiting to be sent
  logic [7:0] rdata_r; // Read data
  logic [2:0] sync1_r, sync2_r, prev_r; // Pin synchronisers
  logic [5:0] pre_cnt_r; // System clock prescaler
  logic [2:0] osc_cnt_r; // External oscillator divider
  logic tx_half_r, rx_half_r; // Overflow halvers
  uaf_tx_e tx_st_r;
  logic [8:0] tx_sh_r; // Bits still to send
  logic [3:0] tx_left_r;
  logic line_out_r; // Registered line level
  uaf_rx_e rx_st_r;
  logic [3:0] rx_idx_r; // Sample index, 0 is start
  logic [8:0] rx_sh_r; // Incoming shift register
  logic tick, tmr_tick, tx_ovf, rx_ovf, tx_bit, start_det, samp;
  logic rx_s, osc_rise, ext_fall, wr_ctrl, ti_set, rx_end, filt_bit, load_ok;
  logic [3:0] stop_idx;
  logic [7:0] rx_byte;
  assign rx_s = sync2_r[0];
  assign osc_rise = sync2_r[2] & ~prev_r[2];
  assign ext_fall = ~sync2_r[1] & prev_r[1];
  assign wr_ctrl = wr_i && addr_i == uaf_pkg::ADDR_CTRL;
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, second stage feeds all logic
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_r <= 3'h7;
      sync2_r <= 3'h7;
      prev_r <= 3'h7;
    end else if (ce_i) begin
      sync1_r <= {ext_osc_i, timer1_external_input_i, line.serial_in_pin};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Timer clock sources: prescaler and oscillator divide-by-8
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pre_cnt_r <= 6'h00;
      osc_cnt_r <= 3'h0;
    end else if (ce_i) begin
      pre_cnt_r <= (pre_cnt_r == uaf_pkg::PRE_LAST) ? 6'h00 : pre_cnt_r + 6'h01;
      if (osc_rise) begin
        osc_cnt_r <= osc_cnt_r + 3'h1;
      end
    end
  end
  // Source select
  always_comb begin
    unique case (clk_sel_r)
      uaf_pkg::SEL_SYS: tick = 1'b1;
      uaf_pkg::SEL_DIV4: tick = pre_cnt_r[1:0] == 2'h3;
      uaf_pkg::SEL_DIV12: tick = (pre_cnt_r % uaf_pkg::PRE_MOD12) == uaf_pkg::PRE_HIT12;
      uaf_pkg::SEL_DIV48: tick = pre_cnt_r == uaf_pkg::PRE_LAST;
      uaf_pkg::SEL_OSC8: tick = osc_rise && osc_cnt_r == uaf_pkg::OSC8_LAST;
      uaf_pkg::SEL_EXT: tick = ext_fall;
      default: tick = 1'b0; // Unused codes stop the timer
    endcase
  end
  assign tmr_tick = tmr_run_r & tick;
  assign tx_ovf = tmr_tick && baud_timer_low_count_r == uaf_pkg::TMR_TOP;
  assign rx_ovf = tmr_tick && rx_tmr_r == uaf_pkg::TMR_TOP && !start_det;
  assign tx_bit = tx_ovf & tx_half_r;
  assign samp = rx_ovf && !rx_half_r && rx_st_r == RX_BITS;
  ////////////////////////////////////////////////////////////////////////////
  // Baud timer, auto-reload, and its hidden receive copy
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      baud_timer_low_count_r <= 8'h00;
      rx_tmr_r <= 8'h00;
      tx_half_r <= 1'b0;
      rx_half_r <= 1'b0;
    end else if (ce_i) begin
      if (wr_i && addr_i == uaf_pkg::ADDR_TLOW) begin
        baud_timer_low_count_r <= wdata_i;
      end else if (tmr_tick) begin
        baud_timer_low_count_r <= tx_ovf ? baud_reload_value_r : baud_timer_low_count_r + 8'h01;
      end
      if (start_det) begin
        rx_tmr_r <= baud_reload_value_r; // Forced reload
        rx_half_r <= 1'b0;
      end else if (tmr_tick) begin
        rx_tmr_r <= rx_ovf ? baud_reload_value_r : rx_tmr_r + 8'h01;
        rx_half_r <= rx_half_r ^ rx_ovf;
      end
      if (tx_ovf) begin
        tx_half_r <= ~tx_half_r;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Transmitter, independent of the receiver
  assign ti_set = tx_bit && tx_st_r == TX_DATA && tx_left_r == 4'h0;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_st_r <= TX_IDLE;
      tx_sh_r <= 9'h000;
      tx_left_r <= 4'h0;
      line_out_r <= 1'b1;
      tx_pend_r <= 1'b0;
      tx_hold_r <= 8'h00;
    end else if (ce_i) begin
      if (wr_i && addr_i == uaf_pkg::ADDR_DATA) begin
        tx_hold_r <= wdata_i; // Writes always reach transmit
        tx_pend_r <= 1'b1;
      end
      if (tx_bit) begin
        unique case (tx_st_r)
          TX_DATA: begin
            if (tx_left_r == 4'h0) begin
              line_out_r <= 1'b1; // Stop bit
              tx_st_r <= TX_STOP;
            end else begin
              line_out_r <= tx_sh_r[0]; // LSB first
              tx_sh_r <= {1'b1, tx_sh_r[8:1]};
              tx_left_r <= tx_left_r - 4'h1;
            end
          end
          default: begin
            if (tx_pend_r && !(wr_i && addr_i == uaf_pkg::ADDR_DATA)) begin
              line_out_r <= 1'b0; // Start bit
              tx_sh_r <= {tx_ninth_bit_r, tx_hold_r};
              tx_left_r <= frame_format_select_r ? uaf_pkg::DATA_BITS + 4'h1 : uaf_pkg::DATA_BITS;
              tx_pend_r <= 1'b0;
              tx_st_r <= TX_DATA;
            end else begin
              line_out_r <= 1'b1;
              tx_st_r <= TX_IDLE;
            end
          end
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  assign start_det = receive_enable_bit_r && tmr_run_r && rx_st_r == RX_IDLE && prev_r[0] && !rx_s;
  assign stop_idx = frame_format_select_r ? uaf_pkg::STOP_IDX9 : uaf_pkg::STOP_IDX8;
  assign rx_end = samp && rx_idx_r == stop_idx;
  assign rx_byte = frame_format_select_r ? rx_sh_r[7:0] : rx_sh_r[8:1];
  assign filt_bit = frame_format_select_r ? rx_sh_r[8] : rx_s; // Ninth or stop
  assign load_ok = rx_end && !rx_done_flag_r && (!address_filter_enable_r || filt_bit);
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_st_r <= RX_IDLE;
      rx_idx_r <= 4'h0;
      rx_sh_r <= 9'h000;
    end else if (ce_i) begin
      if (start_det) begin
        rx_st_r <= RX_BITS;
        rx_idx_r <= 4'h0;
      end else if (samp) begin
        if (rx_idx_r == 4'h0 && rx_s) begin
          rx_st_r <= RX_IDLE; // Glitch, not a start bit
        end else if (rx_end) begin
          rx_st_r <= RX_IDLE;
        end else begin
          if (rx_idx_r != 4'h0) begin
            rx_sh_r <= {rx_s, rx_sh_r[8:1]}; // Shifts while buffer holds
          end
          rx_idx_r <= rx_idx_r + 4'h1;
        end
      end
    end
  end
  // Receive buffer, loaded only when allowed
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rx_buf_r <= 8'h00;
    end else if (ce_i && load_ok) begin
      rx_buf_r <= rx_byte;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Control register; hardware set beats software clear
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      frame_format_select_r <= uaf_pkg::CTRL_RST[uaf_pkg::B_MODE];
      address_filter_enable_r <= uaf_pkg::CTRL_RST[uaf_pkg::B_MCE];
      receive_enable_bit_r <= uaf_pkg::CTRL_RST[uaf_pkg::B_REN];
      tx_ninth_bit_r <= uaf_pkg::CTRL_RST[uaf_pkg::B_TB8];
      rx_ninth_bit_r <= uaf_pkg::CTRL_RST[uaf_pkg::B_RB8];
      tx_done_flag_r <= uaf_pkg::CTRL_RST[uaf_pkg::B_TI];
      rx_done_flag_r <= uaf_pkg::CTRL_RST[uaf_pkg::B_RI];
    end else if (ce_i) begin
      if (wr_ctrl) begin
        frame_format_select_r <= wdata_i[uaf_pkg::B_MODE];
        address_filter_enable_r <= wdata_i[uaf_pkg::B_MCE];
        receive_enable_bit_r <= wdata_i[uaf_pkg::B_REN];
        tx_ninth_bit_r <= wdata_i[uaf_pkg::B_TB8];
      end
      // Hardware events first, then a software write
      rx_ninth_bit_r <= load_ok ? filt_bit : wr_ctrl ? wdata_i[uaf_pkg::B_RB8] : rx_ninth_bit_r;
      tx_done_flag_r <= ti_set ? 1'b1 : wr_ctrl ? wdata_i[uaf_pkg::B_TI] : tx_done_flag_r;
      rx_done_flag_r <= load_ok ? 1'b1 : wr_ctrl ? wdata_i[uaf_pkg::B_RI] : rx_done_flag_r;
    end
  end
  // Timer control registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      baud_reload_value_r <= uaf_pkg::RELOAD_RST;
      tmr_run_r <= 1'b0;
      clk_sel_r <= uaf_pkg::SEL_SYS;
    end else if (ce_i && wr_i) begin
      if (addr_i == uaf_pkg::ADDR_RELOAD) begin
        baud_reload_value_r <= wdata_i;
      end
      if (addr_i == uaf_pkg::ADDR_TCTRL) begin
        tmr_run_r <= wdata_i[uaf_pkg::B_RUN];
        clk_sel_r <= wdata_i[uaf_pkg::B_SEL_LO +: 3];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_r <= 8'h00;
    end else if (ce_i) begin
      rdata_r <= 8'h00;
      if (rd_i) begin
        unique case (addr_i)
          uaf_pkg::ADDR_CTRL: rdata_r <= {frame_format_select_r, 1'b1, address_filter_enable_r,
            receive_enable_bit_r, tx_ninth_bit_r, rx_ninth_bit_r, tx_done_flag_r, rx_done_flag_r};
          uaf_pkg::ADDR_DATA: rdata_r <= rx_buf_r; // Receive side only
          uaf_pkg::ADDR_TLOW: rdata_r <= baud_timer_low_count_r;
          uaf_pkg::ADDR_RELOAD: rdata_r <= baud_reload_value_r;
          uaf_pkg::ADDR_TCTRL: rdata_r <= {4'h0, clk_sel_r, tmr_run_r};
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end
  assign rdata_o = rdata_r;
  assign irq_o = tx_done_flag_r | rx_done_flag_r;
  assign line.serial_out_pin = line_out_r;
endmodule : uaf_dev

// >>> core/uaf_line_if.sv
// Serial line between the port and its partner
`timescale 1ns/1ps
interface uaf_line_if;
  logic serial_out_pin; // Port to partner, idles high
  logic serial_in_pin; // Partner to port, idles high
  // Documented port end
  modport dev (output serial_out_pin, input serial_in_pin);
  // Partner end
  modport peer (input serial_out_pin, output serial_in_pin);
endinterface : uaf_line_if

// >>> core/uaf_peer.sv
// Line partner: plain UART with a fixed bit period in cycles
`timescale 1ns/1ps
module uaf_peer (
  // Clock, reset, clock enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Frame setup
  input wire logic [15:0] bit_cycles_i,
  input wire logic nine_bit_i,
  // Transmit request
  input wire logic tx_valid_i,
  input wire logic [8:0] tx_data_i,
  output logic tx_ready_o,
  // Receive result
  output logic rx_valid_o,
  output logic [8:0] rx_data_o,
  output logic rx_stop_o,
  // Serial line
  uaf_line_if.peer line
);
  logic [10:0] tx_sh_r; // Frame bits, LSB on line
  logic [3:0] tx_left_r; // Bits still to send
  logic [15:0] tx_cnt_r; // Bit period counter
  logic sync1_r, sync2_r, prev_r; // Line synchroniser
  logic rx_busy_r;
  logic [3:0] rx_idx_r;
  logic [15:0] rx_cnt_r;
  logic [9:0] rx_sh_r;
  logic rx_valid_r;
  logic [8:0] rx_data_r;
  logic rx_stop_r;
  logic [3:0] rx_last;

  assign tx_ready_o = tx_left_r == 4'h0;
  assign line.serial_in_pin = tx_sh_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter; ninth bit marks addresses
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_sh_r <= 11'h7ff; // Idle high
      tx_left_r <= 4'h0;
      tx_cnt_r <= 16'h0000;
    end else if (ce_i) begin
      if (tx_left_r == 4'h0) begin
        if (tx_valid_i) begin
          tx_sh_r <= nine_bit_i ? {1'b1, tx_data_i, 1'b0} : {2'h3, tx_data_i[7:0], 1'b0};
          tx_left_r <= nine_bit_i ? uaf_pkg::STOP_IDX9 + 4'h1 : uaf_pkg::STOP_IDX8 + 4'h1;
          tx_cnt_r <= bit_cycles_i - 16'h0001;
        end
      end else if (tx_cnt_r == 16'h0000) begin
        tx_sh_r <= {1'b1, tx_sh_r[10:1]};
        tx_left_r <= tx_left_r - 4'h1;
        tx_cnt_r <= bit_cycles_i - 16'h0001;
      end else begin
        tx_cnt_r <= tx_cnt_r - 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver, samples mid-bit
  assign rx_last = nine_bit_i ? uaf_pkg::STOP_IDX9 : uaf_pkg::STOP_IDX8;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r <= 1'b1;
      rx_busy_r <= 1'b0;
      rx_idx_r <= 4'h0;
      rx_cnt_r <= 16'h0000;
      rx_sh_r <= 10'h000;
      rx_valid_r <= 1'b0;
      rx_data_r <= 9'h000;
      rx_stop_r <= 1'b1;
    end else if (ce_i) begin
      sync1_r <= line.serial_out_pin;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
      rx_valid_r <= 1'b0;
      if (!rx_busy_r) begin
        if (prev_r && !sync2_r) begin
          rx_busy_r <= 1'b1; // Falling edge starts a frame
          rx_idx_r <= 4'h0;
          rx_cnt_r <= {1'b0, bit_cycles_i[15:1]};
        end
      end else if (rx_cnt_r != 16'h0000) begin
        rx_cnt_r <= rx_cnt_r - 16'h0001;
      end else begin
        rx_cnt_r <= bit_cycles_i - 16'h0001;
        rx_idx_r <= rx_idx_r + 4'h1;
        rx_sh_r <= {sync2_r, rx_sh_r[9:1]};
        if (rx_idx_r == 4'h0 && sync2_r) begin
          rx_busy_r <= 1'b0; // False start
        end else if (rx_idx_r == rx_last) begin
          rx_busy_r <= 1'b0;
          rx_valid_r <= 1'b1;
          rx_stop_r <= sync2_r;
          rx_data_r <= nine_bit_i ? rx_sh_r[9:1] : {1'b0, rx_sh_r[9:2]};
        end
      end
    end
  end

  assign rx_valid_o = rx_valid_r;
  assign rx_data_o = rx_data_r;
  assign rx_stop_o = rx_stop_r;
endmodule : uaf_peer

// >>> core/uaf_pkg.sv
// Shared constants for the address-filtering serial port and its line partner
// How it works
// - Transmitter and receiver run independently, full duplex
// - Received byte held while next one shifts
// - Data writes load transmit; reads return receive
// - Done flags request interrupt; only software clears
// - Baud from 8-bit auto-reload timer plus copy
// - Both timer overflows halved into bit rate
// - Receive copy reloads on start-bit detection
// - Software picks reload: overflow is twice bitrate
// - Six selectable baud timer clock sources
// - Control bit 7 picks 8-bit or 9-bit
// - 8-bit frame: start, eight LSB-first, stop
// - Data write starts send; done at stop
// - Reception only while receive enable set
// - 8-bit load: flag clear, filter needs stop
// - Failed load leaves buffer, ninth, flag alone
// - Overrun keeps first byte, drops later one
// - 9-bit frame carries software ninth bit
// - 9-bit: ninth stored, filter needs ninth one
// - Master marks address bytes with ninth one
// - Slave software toggles filter around its messages
package uaf_pkg;
  // Register addresses on the CPU port
  localparam logic [7:0] ADDR_CTRL = 8'h98;
  localparam logic [7:0] ADDR_DATA = 8'h99;
  localparam logic [7:0] ADDR_TLOW = 8'h8b;
  localparam logic [7:0] ADDR_RELOAD = 8'h8d;
  localparam logic [7:0] ADDR_TCTRL = 8'h8e;
  // Control register bit positions
  localparam int B_MODE = 7;
  localparam int B_ONE = 6;
  localparam int B_MCE = 5;
  localparam int B_REN = 4;
  localparam int B_TB8 = 3;
  localparam int B_RB8 = 2;
  localparam int B_TI = 1;
  localparam int B_RI = 0;
  // Timer control register fields
  localparam int B_RUN = 0;
  localparam int B_SEL_LO = 1;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h40;
  localparam logic [7:0] RELOAD_RST = 8'h00;
  // Baud timer clock sources
  localparam logic [2:0] SEL_SYS = 3'h0;
  localparam logic [2:0] SEL_DIV4 = 3'h1;
  localparam logic [2:0] SEL_DIV12 = 3'h2;
  localparam logic [2:0] SEL_DIV48 = 3'h3;
  localparam logic [2:0] SEL_OSC8 = 3'h4;
  localparam logic [2:0] SEL_EXT = 3'h5;
  // Prescaler counts
  localparam logic [5:0] PRE_LAST = 6'h2f;
  localparam logic [5:0] PRE_MOD12 = 6'h0c;
  localparam logic [5:0] PRE_HIT12 = 6'h0b;
  localparam logic [2:0] OSC8_LAST = 3'h7;
  localparam logic [7:0] TMR_TOP = 8'hff;
  // Frame shapes: data bits, and index of the stop sample
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [3:0] STOP_IDX8 = 4'h9;
  localparam logic [3:0] STOP_IDX9 = 4'ha;
endpackage : uaf_pkg

// >>> tb/testbench.sv
// Self-checking bench: port and line partner joined back to back
`timescale 1ns/1ps
module testbench;
  // Table row: timer setup, format, data, expected load
  typedef struct packed {
    logic [2:0] sel;
    logic [7:0] rel;
    logic [15:0] bitc;
    logic mode;
    logic mce;
    logic ninth;
    logic [7:0] data;
    logic load;
  } uaf_row_s;
  localparam uaf_row_s ROWS [5] = '{
    '{uaf_pkg::SEL_SYS, 8'hfc, 16'h0008, 1'b0, 1'b0, 1'b0, 8'ha5, 1'b1},
    '{uaf_pkg::SEL_SYS, 8'hfc, 16'h0008, 1'b1, 1'b0, 1'b0, 8'h3c, 1'b1},
    '{uaf_pkg::SEL_SYS, 8'hfc, 16'h0008, 1'b1, 1'b1, 1'b0, 8'h5a, 1'b0},
    '{uaf_pkg::SEL_SYS, 8'hfc, 16'h0008, 1'b1, 1'b1, 1'b1, 8'h81, 1'b1},
    '{uaf_pkg::SEL_DIV4, 8'hfe, 16'h0010, 1'b0, 1'b1, 1'b0, 8'h0f, 1'b1}
  };
  // Clock, reset, CPU port
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ce = 1'b1; // Port clock enable
  logic [7:0] rdata_o;
  logic irq_o;
  // Partner user side
  logic [15:0] bit_cyc = 16'h0008;
  logic nine_bit = 1'b0;
  logic ptx_valid = 1'b0;
  logic [8:0] ptx_data = 9'h000;
  logic ptx_ready;
  logic prx_valid;
  logic [8:0] prx_data;
  // Bench state
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic rx_seen = 1'b0;
  logic [7:0] buf_q = 8'h00;
  logic rx9_q = 1'b0;
  logic [7:0] c;
  logic [7:0] d;
  ////////////////////////////////////////////////////////////////////////////
  uaf_line_if line ();
  uaf_dev u_uaf_dev (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .ext_osc_i(1'b0),
    .timer1_external_input_i(1'b0), .line(line));
  uaf_peer u_uaf_peer (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .bit_cycles_i(bit_cyc),
    .nine_bit_i(nine_bit), .tx_valid_i(ptx_valid), .tx_data_i(ptx_data), .tx_ready_o(ptx_ready),
    .rx_valid_o(prx_valid), .rx_data_o(prx_data), .rx_stop_o(), .line(line));
  uaf_line_chk u_uaf_line_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .serial_out_pin(line.serial_out_pin),
    .serial_in_pin(line.serial_in_pin));
  ////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  always #12.5 clk_i = ~clk_i;
  // Note a frame taken by the partner
  always @(posedge clk_i) begin
    if (prx_valid === 1'b1) begin
      rx_seen <= 1'b1;
    end
  end
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string what, input logic [8:0] sv, input logic [8:0] ev);
    comparisons++;
    if (sv !== ev) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, ev, sv);
    end
  endtask : chk
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Read; data stands the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd
  // Both directions at once, wait for both to finish
  task automatic frame(input logic [8:0] pv, input logic [7:0] dv);
    int n;
    rx_seen = 1'b0;
    wr(uaf_pkg::ADDR_DATA, dv);
    ptx_data <= pv;
    ptx_valid <= 1'b1;
    do @(posedge clk_i); while (ptx_ready !== 1'b1);
    ptx_valid <= 1'b0;
    n = 0;
    while (!(rx_seen && ptx_ready === 1'b1) && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    chk("frame_end", {8'h00, rx_seen}, 9'h001);
    repeat (4) @(posedge clk_i);
  endtask : frame
  // Verdict and end of run
  task automatic results();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(uaf_pkg::ADDR_CTRL, c);
    chk("ctrl_rst", {1'b0, c}, {1'b0, uaf_pkg::CTRL_RST});
    rd(8'h00, d);
    chk("unmapped", {1'b0, d}, 9'h000);
    chk("irq_rst", {8'h00, irq_o}, 9'h000);
    // Table rows: timer source, format, filter
    for (int i = 0; i < 5; i++) begin
      wr(uaf_pkg::ADDR_TCTRL, {4'h0, ROWS[i].sel, 1'b1});
      wr(uaf_pkg::ADDR_RELOAD, ROWS[i].rel);
      wr(uaf_pkg::ADDR_TLOW, ROWS[i].rel);
      bit_cyc <= ROWS[i].bitc;
      nine_bit <= ROWS[i].mode;
      wr(uaf_pkg::ADDR_CTRL, {ROWS[i].mode, 1'b1, ROWS[i].mce, 1'b1, ROWS[i].ninth, 3'h0});
      frame({ROWS[i].ninth, ROWS[i].data}, ~ROWS[i].data);
      chk("peer_rx", prx_data, {ROWS[i].mode & ROWS[i].ninth, ~ROWS[i].data});
      // Loaded rows move buffer and ninth field
      if (ROWS[i].load) begin
        buf_q = ROWS[i].data;
        rx9_q = ROWS[i].mode ? ROWS[i].ninth : 1'b1;
      end
      rd(uaf_pkg::ADDR_CTRL, c);
      chk("rx_done", {8'h00, c[0]}, {8'h00, ROWS[i].load});
      chk("rx_ninth", {8'h00, c[2]}, {8'h00, rx9_q});
      chk("tx_done", {8'h00, c[1]}, 9'h001);
      chk("irq", {8'h00, irq_o}, 9'h001);
      rd(uaf_pkg::ADDR_DATA, d);
      chk("rx_buf", {1'b0, d}, {1'b0, buf_q});
    end
    // Receiver off: frame arrives, nothing loads
    wr(uaf_pkg::ADDR_CTRL, 8'h40);
    frame(9'h077, 8'h11);
    rd(uaf_pkg::ADDR_CTRL, c);
    chk("rx_off", {8'h00, c[0]}, 9'h000);
    // Overrun keeps the first byte
    wr(uaf_pkg::ADDR_CTRL, 8'h50);
    frame(9'h011, 8'h22);
    frame(9'h022, 8'h33);
    rd(uaf_pkg::ADDR_DATA, d);
    chk("overrun", {1'b0, d}, 9'h011);
    // Flags stay until software clears them
    repeat (50) @(posedge clk_i);
    chk("irq_hold", {8'h00, irq_o}, 9'h001);
    wr(uaf_pkg::ADDR_CTRL, 8'h50);
    #1;
    chk("irq_clear", {8'h00, irq_o}, 9'h000);
    // Clock enable low: a write is ignored
    ce <= 1'b0;
    wr(uaf_pkg::ADDR_RELOAD, 8'h12);
    ce <= 1'b1;
    rd(uaf_pkg::ADDR_RELOAD, d);
    chk("ce_hold", {1'b0, d}, {1'b0, ROWS[4].rel});
    results();
  end
endmodule : testbench

// >>> tb/uaf_line_chk.sv
// Line checks on both directions of the serial link
`timescale 1ns/1ps
module uaf_line_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Serial line
  input wire logic serial_out_pin,
  input wire logic serial_in_pin
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // Lines are high as reset lets go
  property p_out_rst_idle;
    $rose(rst_n_i) |-> serial_out_pin;
  endproperty
  property p_in_rst_idle;
    $rose(rst_n_i) |-> serial_in_pin;
  endproperty
  // Every low or high run is at least one bit of eight cycles
  property p_out_low_run;
    $fell(serial_out_pin) |-> !serial_out_pin [*8];
  endproperty
  property p_out_high_run;
    $rose(serial_out_pin) |-> serial_out_pin [*8];
  endproperty
  property p_in_low_run;
    $fell(serial_in_pin) |-> !serial_in_pin [*8];
  endproperty
  property p_in_high_run;
    $rose(serial_in_pin) |-> serial_in_pin [*8];
  endproperty
  // Stop bit ends any low run within 160 cycles, ten bits of sixteen cycles
  property p_out_low_max;
    $fell(serial_out_pin) |-> ##[8:160] serial_out_pin;
  endproperty
  property p_in_low_max;
    $fell(serial_in_pin) |-> ##[8:160] serial_in_pin;
  endproperty
  ////////////////////////////////////////////////////////////////////////////
  a_out_rst_idle: assert property (p_out_rst_idle) else $error("out line low after reset");
  a_in_rst_idle: assert property (p_in_rst_idle) else $error("in line low after reset");
  a_out_low_run: assert property (p_out_low_run) else $error("out low run short");
  a_out_high_run: assert property (p_out_high_run) else $error("out high run short");
  a_in_low_run: assert property (p_in_low_run) else $error("in low run short");
  a_in_high_run: assert property (p_in_high_run) else $error("in high run short");
  a_out_low_max: assert property (p_out_low_max) else $error("out frame lacks stop");
  a_in_low_max: assert property (p_in_low_max) else $error("in frame lacks stop");
  // Main traffic seen
  c_out_frame: cover property ($fell(serial_out_pin));
  c_in_frame: cover property ($fell(serial_in_pin));
  c_in_long: cover property (!serial_in_pin [*8] ##1 serial_in_pin);
endmodule : uaf_line_chk
